/* rsc_pin_filter.sv */
// Glitch filter for the active-low external reset pin.
`timescale 1ns/10ps
module rsc_pin_filter (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic ce_i,
   input  wire logic pin_b_i,
   output logic      low_o
);

   rsc_pkg::rsc_filt_state_t st;
   rsc_pkg::rsc_filt_state_t next_st;

   // A low pulse counts only once it has lasted the full least width.
   always_comb begin
      next_st = st;
      if (pin_b_i) begin
         next_st.cnt = 8'h00;
         next_st.low = 1'b0;
      end else if (st.cnt == 8'(rsc_pkg::PIN_MIN_CYC - 1)) begin
         next_st.low = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign low_o = st.low;

   filt_width_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(st.low) |-> st.cnt == 8'(rsc_pkg::PIN_MIN_CYC - 1) && !$past(pin_b_i))
      else $error("reset pin accepted before least width");

endmodule

/* rsc_pkg.sv */
// Shared constants and types for the reset source controller.
package rsc_pkg;

   localparam int unsigned CLK_PERIOD_NS = 20;

   // Power-on settle time, a longest time, rounded down.
   localparam int unsigned POR_SETTLE_NS  = 30000;
   localparam int unsigned POR_SETTLE_CYC = POR_SETTLE_NS / CLK_PERIOD_NS;

   // Brown-out settle time, a longest time, rounded down.
   localparam int unsigned BOR_SETTLE_NS  = 100000;
   localparam int unsigned BOR_SETTLE_CYC = BOR_SETTLE_NS / CLK_PERIOD_NS;

   // One millisecond of power-up delay, in cycles.
   localparam int unsigned MS_NS      = 1000000;
   localparam int unsigned MS_CYC     = MS_NS / CLK_PERIOD_NS;

   // Least low time on the reset pin, rounded up.
   localparam int unsigned PIN_MIN_NS  = 2000;
   localparam int unsigned PIN_MIN_CYC = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Power-up delay in milliseconds for each of the eight select codes.
   localparam logic [7:0][7:0] POWERUP_DELAY_TIMER_MS_TABLE = {8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h00};

   // Register byte offsets.
   localparam logic [7:0] CAUSE_OFS  = 8'h00;
   localparam logic [7:0] MASK_OFS   = 8'h04;
   localparam logic [7:0] CONFIG_OFS = 8'h08;

   // Cause register bit positions.
   localparam int unsigned POR_BIT  = 0;
   localparam int unsigned BOR_BIT  = 1;
   localparam int unsigned WDT_BIT  = 4;
   localparam int unsigned SOFT_BIT = 6;
   localparam int unsigned PIN_BIT  = 7;
   localparam int unsigned TRAP_BIT = 15;

   localparam logic [15:0] CAUSE_IMPL   = 16'h80d3;
   localparam logic [15:0] CAUSE_RESET  = 16'h0001;
   localparam logic [15:0] MASK_RESET   = 16'h0000;
   localparam logic [2:0]  SELECT_RESET = 3'h7;

   // Lowest priority level that counts as a hard trap.
   localparam logic [3:0] HARD_TRAP_MIN = 4'hd;

   typedef enum logic [2:0] {
      RSC_POR_WAIT,
      RSC_POR_SETTLE,
      RSC_BOR_HOLD,
      RSC_BOR_SETTLE,
      RSC_POWERUP_DELAY_TIMER,
      RSC_RUN,
      RSC_PIN,
      RSC_BRIEF
   } rsc_fsm_t;

   typedef struct packed {
      logic       valid;
      logic [3:0] level;
   } rsc_trap_t;

   typedef struct packed {
      rsc_fsm_t    fsm;
      logic [23:0] cnt;
      logic [15:0] cause;
      logic [15:0] mask;
      logic [2:0]  sel;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] rdata;
      logic        wake;
   } rsc_state_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic       low;
   } rsc_filt_state_t;

endpackage

/* rsc_reset_source_controller.sv */
// Reset source controller: sequencing, cause register and bus slave.
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
module rsc_reset_source_controller #(
   parameter int unsigned BOR_CYC = rsc_pkg::BOR_SETTLE_CYC,
   parameter int unsigned MS_CYC  = rsc_pkg::MS_CYC
) (
   input  wire logic                clk_i,
   input  wire logic                rst_b_i,
   input  wire logic                ce_i,
   input  wire logic                por_ok_i,
   input  wire logic                brownout_i,
   input  wire logic                ext_reset_pin_b_i,
   input  wire logic                soft_reset_i,
   input  wire logic                wdt_expire_i,
   input  wire logic                cpu_sleep_i,
   input  wire rsc_pkg::rsc_trap_t  trap_new_i,
   input  wire rsc_pkg::rsc_trap_t  trap_busy_i,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic                     hresp,
   output logic [31:0]              hrdata,
   output logic                     system_reset_o,
   output logic                     clock_reinit_o,
   output logic                     wake_o,
   output logic                     irq_o
);

   rsc_pkg::rsc_state_t st;
   rsc_pkg::rsc_state_t next_st;

   logic        pin_low;
   logic        trap_clash;
   logic        wdt_reset;
   logic        addr_take;
   logic [15:0] cause_set;
   logic [15:0] cause_clr;
   logic [23:0] powerup_delay_timer_cyc;

   rsc_pin_filter u_filter (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .ce_i    (ce_i),
      .pin_b_i (ext_reset_pin_b_i),
      .low_o   (pin_low)
   );

   assign trap_clash = trap_new_i.valid && trap_busy_i.valid
                       && trap_new_i.level >= rsc_pkg::HARD_TRAP_MIN
                       && trap_busy_i.level >= rsc_pkg::HARD_TRAP_MIN
                       && trap_new_i.level < trap_busy_i.level;
   assign wdt_reset  = wdt_expire_i && !cpu_sleep_i;
   assign powerup_delay_timer_cyc   = 24'(rsc_pkg::POWERUP_DELAY_TIMER_MS_TABLE[st.sel] * MS_CYC);
   assign addr_take  = hsel && htrans[1] && hready && ce_i;

   always_comb begin
      next_st   = st;
      cause_set = 16'h0000;
      cause_clr = 16'h0000;
      next_st.wake = 1'b0;
      case (st.fsm)
         rsc_pkg::RSC_POR_WAIT: begin
            if (por_ok_i) begin
               next_st.fsm = rsc_pkg::RSC_POR_SETTLE;
               next_st.cnt = 24'(rsc_pkg::POR_SETTLE_CYC - 1);
            end
         end
         rsc_pkg::RSC_POR_SETTLE: begin
            if (!por_ok_i) begin
               next_st.fsm = rsc_pkg::RSC_POR_WAIT;
            end else if (st.cnt == 24'h000000) begin
               cause_set[rsc_pkg::POR_BIT] = 1'b1;
               if (powerup_delay_timer_cyc == 24'h000000) begin
                  next_st.fsm = rsc_pkg::RSC_RUN;
               end else begin
                  next_st.fsm = rsc_pkg::RSC_POWERUP_DELAY_TIMER;
                  next_st.cnt = powerup_delay_timer_cyc - 24'h000001;
               end
            end else begin
               next_st.cnt = st.cnt - 24'h000001;
            end
         end
         rsc_pkg::RSC_BOR_HOLD: begin
            if (!brownout_i) begin
               next_st.fsm = rsc_pkg::RSC_BOR_SETTLE;
               next_st.cnt = 24'(BOR_CYC - 1);
            end
         end
         rsc_pkg::RSC_BOR_SETTLE: begin
            if (st.cnt == 24'h000000) begin
               if (powerup_delay_timer_cyc == 24'h000000) begin
                  next_st.fsm = rsc_pkg::RSC_RUN;
               end else begin
                  next_st.fsm = rsc_pkg::RSC_POWERUP_DELAY_TIMER;
                  next_st.cnt = powerup_delay_timer_cyc - 24'h000001;
               end
            end else begin
               next_st.cnt = st.cnt - 24'h000001;
            end
         end
         rsc_pkg::RSC_POWERUP_DELAY_TIMER: begin
            if (st.cnt == 24'h000000) begin
               next_st.fsm = rsc_pkg::RSC_RUN;
            end else begin
               next_st.cnt = st.cnt - 24'h000001;
            end
         end
         rsc_pkg::RSC_RUN: begin
            if (trap_clash) begin
               next_st.fsm = rsc_pkg::RSC_BRIEF;
               cause_set[rsc_pkg::TRAP_BIT] = 1'b1;
            end else if (wdt_reset) begin
               next_st.fsm = rsc_pkg::RSC_BRIEF;
               cause_set[rsc_pkg::WDT_BIT] = 1'b1;
            end else if (soft_reset_i) begin
               next_st.fsm = rsc_pkg::RSC_BRIEF;
               cause_set[rsc_pkg::SOFT_BIT] = 1'b1;
            end else if (pin_low) begin
               next_st.fsm = rsc_pkg::RSC_PIN;
               cause_set[rsc_pkg::PIN_BIT] = 1'b1;
            end
            if (wdt_expire_i && cpu_sleep_i) begin
               next_st.wake = 1'b1;
            end
         end
         rsc_pkg::RSC_PIN: begin
            if (!pin_low) begin
               next_st.fsm = rsc_pkg::RSC_RUN;
            end
         end
         rsc_pkg::RSC_BRIEF: begin
            next_st.fsm = rsc_pkg::RSC_RUN;
         end
         default: begin
            next_st.fsm = rsc_pkg::RSC_POR_WAIT;
         end
      endcase

      // A brown-out overrides every other reset source and the wake once power-on has settled.
      if (brownout_i && st.fsm != rsc_pkg::RSC_POR_WAIT && st.fsm != rsc_pkg::RSC_POR_SETTLE) begin
         next_st.fsm = rsc_pkg::RSC_BOR_HOLD;
         next_st.wake = 1'b0;
         cause_set = 16'h0000;
         cause_set[rsc_pkg::BOR_BIT] = 1'b1;
      end

      // Data phase of a write.
      if (st.wr_pend) begin
         case (st.wr_addr)
            rsc_pkg::CAUSE_OFS: begin
               cause_clr = hwdata[15:0];
            end
            rsc_pkg::MASK_OFS: begin
               next_st.mask = hwdata[15:0] & rsc_pkg::CAUSE_IMPL;
            end
            rsc_pkg::CONFIG_OFS: begin
               next_st.sel = hwdata[2:0];
            end
            default: begin
            end
         endcase
      end

      // Set beats clear so an event in the clearing cycle survives.
      next_st.cause = ((st.cause & ~cause_clr) | cause_set) & rsc_pkg::CAUSE_IMPL;

      // Address phase.
      next_st.wr_pend = addr_take && hwrite;
      next_st.wr_addr = haddr[7:0];
      if (addr_take && !hwrite) begin
         case (haddr[7:0])
            rsc_pkg::CAUSE_OFS:  next_st.rdata = {16'h0000, st.cause};
            rsc_pkg::MASK_OFS:   next_st.rdata = {16'h0000, st.mask};
            rsc_pkg::CONFIG_OFS: next_st.rdata = {29'h00000000, st.sel};
            default:             next_st.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         st.fsm     <= rsc_pkg::RSC_POR_WAIT;
         st.cnt     <= 24'h000000;
         st.cause   <= rsc_pkg::CAUSE_RESET;
         st.mask    <= rsc_pkg::MASK_RESET;
         st.sel     <= rsc_pkg::SELECT_RESET;
         st.wr_pend <= 1'b0;
         st.wr_addr <= 8'h00;
         st.rdata   <= 32'h00000000;
         st.wake    <= 1'b0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   // The watchdog path bypasses the flops so reset asserts at once.
   assign system_reset_o = (st.fsm != rsc_pkg::RSC_RUN)
                           || (st.fsm == rsc_pkg::RSC_RUN && wdt_reset);
   // The clock system restarts only for supply and pin resets.
   assign clock_reinit_o = st.fsm != rsc_pkg::RSC_RUN && st.fsm != rsc_pkg::RSC_BRIEF;
   assign wake_o    = st.wake;
   assign irq_o     = |(st.cause & st.mask);
   assign hreadyout = ce_i;
   assign hresp     = 1'b0;
   assign hrdata    = st.rdata;

   por_hold_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_POR_WAIT |-> system_reset_o && clock_reinit_o)
      else $error("reset released before power-on settled");

   por_flag_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_POR_SETTLE && st.cnt == 24'h000000 && por_ok_i && !brownout_i && ce_i
      |=> st.cause[rsc_pkg::POR_BIT] && st.fsm inside {rsc_pkg::RSC_POWERUP_DELAY_TIMER, rsc_pkg::RSC_RUN})
      else $error("power-on flag or release missing");

   bor_enter_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      brownout_i && ce_i && !(st.fsm inside {rsc_pkg::RSC_POR_WAIT, rsc_pkg::RSC_POR_SETTLE})
      |=> st.fsm == rsc_pkg::RSC_BOR_HOLD && st.cause[rsc_pkg::BOR_BIT] && system_reset_o)
      else $error("brown-out not entered");

   bor_restart_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_BOR_HOLD && !brownout_i && ce_i
      |=> st.fsm == rsc_pkg::RSC_BOR_SETTLE && st.cnt == 24'(BOR_CYC - 1))
      else $error("brown-out settle not restarted");

   powerup_delay_timer_release_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_POWERUP_DELAY_TIMER && ce_i && !brownout_i
      |=> st.fsm == (($past(st.cnt) == 24'h000000) ? rsc_pkg::RSC_RUN : rsc_pkg::RSC_POWERUP_DELAY_TIMER))
      else $error("power-up delay ends at wrong time");

   soft_release_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_RUN && soft_reset_i && !trap_clash && !wdt_reset && !brownout_i && ce_i
      |=> st.fsm == rsc_pkg::RSC_BRIEF && st.cause[rsc_pkg::SOFT_BIT] && !clock_reinit_o
      ##1 (!$past(ce_i) || $past(brownout_i) || !system_reset_o || wdt_reset))
      else $error("software reset not released next cycle");

   wdt_async_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_RUN && wdt_reset |-> system_reset_o && !clock_reinit_o)
      else $error("watchdog did not assert reset");

   wdt_sleep_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_RUN && wdt_expire_i && cpu_sleep_i && !trap_clash && !soft_reset_i
      && !pin_low && !brownout_i && ce_i |=> st.fsm == rsc_pkg::RSC_RUN && wake_o)
      else $error("watchdog in sleep must only wake");

   pin_flag_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_RUN && pin_low && !trap_clash && !wdt_reset && !soft_reset_i
      && !brownout_i && ce_i |=> st.fsm == rsc_pkg::RSC_PIN && st.cause[rsc_pkg::PIN_BIT])
      else $error("pin reset flag missing");

   trap_flag_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_RUN && trap_clash && !brownout_i && ce_i
      |=> st.fsm == rsc_pkg::RSC_BRIEF && st.cause[rsc_pkg::TRAP_BIT])
      else $error("trap-conflict flag missing");

   flag_sticky_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !st.wr_pend |=> (st.cause & $past(st.cause)) == $past(st.cause))
      else $error("cause flag lost without a clear");

   // Further guards on release timing, clock handling and flag upkeep.
   por_retry_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_POR_SETTLE && !por_ok_i && ce_i
      |=> st.fsm == rsc_pkg::RSC_POR_WAIT && system_reset_o)
      else $error("power-on settle not restarted on supply loss");

   bor_hold_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm inside {rsc_pkg::RSC_BOR_HOLD, rsc_pkg::RSC_BOR_SETTLE, rsc_pkg::RSC_POWERUP_DELAY_TIMER}
      |-> system_reset_o)
      else $error("reset released during brown-out recovery");

   bor_settle_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_BOR_SETTLE && st.cnt == 24'h000000 && !brownout_i && ce_i
      |=> st.fsm == (($past(powerup_delay_timer_cyc) == 24'h000000) ? rsc_pkg::RSC_RUN : rsc_pkg::RSC_POWERUP_DELAY_TIMER))
      else $error("power-up delay not chained after brown-out settle");

   cfg_apply_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.wr_pend && st.wr_addr == rsc_pkg::CONFIG_OFS && ce_i
      |=> st.sel == $past(hwdata[2:0]))
      else $error("delay select write lost");

   pin_release_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_PIN && !pin_low && !brownout_i && ce_i |=> st.fsm == rsc_pkg::RSC_RUN)
      else $error("pin reset not released");

   clock_keep_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_BRIEF |-> system_reset_o && !clock_reinit_o)
      else $error("brief reset restarted the clock system");

   brief_one_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_BRIEF && !brownout_i && ce_i |=> st.fsm == rsc_pkg::RSC_RUN)
      else $error("brief reset lasted more than one cycle");

   sleep_quiet_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_RUN && cpu_sleep_i |-> !system_reset_o)
      else $error("reset asserted while asleep");

   wake_pulse_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wake_o && ce_i && !wdt_expire_i |=> !wake_o)
      else $error("wake pulse longer than one cycle");

   trap_hard_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      trap_clash |-> trap_new_i.level inside {4'hd, 4'he} && trap_busy_i.level inside {4'he, 4'hf})
      else $error("trap conflict outside hard trap levels");

   run_stay_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_RUN && !trap_clash && !wdt_expire_i && !soft_reset_i && !pin_low
      && !brownout_i && ce_i |=> st.fsm == rsc_pkg::RSC_RUN)
      else $error("reset entered with no source active");

   clear_apply_a : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st.wr_pend && st.wr_addr == rsc_pkg::CAUSE_OFS && cause_set == 16'h0000 && ce_i
      |=> (st.cause & $past(hwdata[15:0])) == 16'h0000)
      else $error("cause flag not cleared by write");

   soft_cov : cover property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_BRIEF && st.cause[rsc_pkg::SOFT_BIT]);
   bor_cov : cover property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_BOR_SETTLE ##1 st.fsm == rsc_pkg::RSC_BOR_HOLD);
   trap_cov : cover property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_RUN && trap_clash);
   irq_cov : cover property (@(posedge clk_i) disable iff (!rst_b_i) irq_o);
   pin_cov : cover property (@(posedge clk_i) disable iff (!rst_b_i)
      st.fsm == rsc_pkg::RSC_PIN && st.cause[rsc_pkg::PIN_BIT]);

endmodule

/* rsc_supervisor_model.sv */
// Model of the external supervisory circuit that drives the reset pin.
`timescale 1ns/10ps
module rsc_supervisor_model (
   input  wire logic       clk_i,
   input  wire logic       start_i,
   input  wire logic [7:0] len_i,
   output logic            pin_b_o
);
   logic [7:0] left = 8'h00;

   // The pin is tied resistively to the supply, so a released pin reads high.
   assign pin_b_o = (left == 8'h00);

   always @(posedge clk_i) begin
      if (start_i) begin
         left <= len_i;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
endmodule

/* testbench.sv */
// Self-checking testbench for the reset source controller.
`timescale 1ns/10ps
module testbench;
   localparam int unsigned BOR_T = 20;
   localparam int unsigned MS_T  = 10;
   logic               clk_i = 1'b0;
   logic               rst_b_i = 1'b0;
   logic               ce = 1'b1;
   logic               por_ok_i = 1'b0;
   logic               brownout_i = 1'b0;
   logic               soft_reset_i = 1'b0;
   logic               wdt_expire_i = 1'b0;
   logic               cpu_sleep_i = 1'b0;
   rsc_pkg::rsc_trap_t trap_new_i = '0;
   rsc_pkg::rsc_trap_t trap_busy_i = '0;
   logic               hsel = 1'b0;
   logic               hwrite = 1'b0;
   logic [1:0]         htrans = 2'h0;
   logic [2:0]         hsize = 3'h2;
   logic [31:0]        haddr = 32'h0;
   logic [31:0]        hwdata = 32'h0;
   logic               start = 1'b0;
   logic [7:0]         len = 8'h00;
   logic               pin_b;
   logic               hreadyout;
   logic               hresp;
   logic [31:0]        hrdata;
   logic               system_reset_o;
   logic               clock_reinit_o;
   logic               wake_o;
   logic               irq_o;
   int                 miscompares = 0;
   int                 samples_checked = 0;

   always #10 clk_i = ~clk_i;

   rsc_reset_source_controller #(.BOR_CYC(BOR_T), .MS_CYC(MS_T)) i_rsc_reset_source_controller (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .por_ok_i(por_ok_i), .brownout_i(brownout_i),
      .ext_reset_pin_b_i(pin_b), .soft_reset_i(soft_reset_i), .wdt_expire_i(wdt_expire_i),
      .cpu_sleep_i(cpu_sleep_i), .trap_new_i(trap_new_i), .trap_busy_i(trap_busy_i), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .system_reset_o(system_reset_o), .clock_reinit_o(clock_reinit_o), .wake_o(wake_o), .irq_o(irq_o));

   rsc_supervisor_model i_rsc_supervisor_model (.clk_i(clk_i), .start_i(start), .len_i(len), .pin_b_o(pin_b));

   task automatic tally_and_finish;
      $display("Checked %0d values, %0d mismatches", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic hang;
      miscompares++;
      $display("Error at %0t: wait ran out", $time);
      tally_and_finish;
   endtask

   // Waits for the edge at which the slave signals ready.
   task automatic wait_rdy;
      int k;
      k = 0;
      @(posedge clk_i);
      while (hreadyout !== 1'b1) begin
         if (++k > 50) hang;
         @(posedge clk_i);
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      r = hrdata;
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check(r, exp);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   // Counts cycles until system reset drops.
   task automatic wait_rel(output int n);
      n = 0;
      while (system_reset_o !== 1'b0) begin
         @(posedge clk_i);
         #1 n++;
         if (n > 4000) hang;
      end
   endtask

   task automatic t_por;
      int n;
      repeat (50) @(posedge clk_i);
      #1 check(system_reset_o, 1'b1);
      rd_chk(32'h0, 32'h1);
      rd_chk(32'h4, 32'h0);
      rd_chk(32'h8, 32'h7);
      rd_chk(32'hc, 32'h0);
      check(hresp, 1'b0);
      @(posedge clk_i);
      por_ok_i <= 1'b1;
      wait_rel(n);
      check(32'(n >= 2776 && n <= 2786), 32'h1);
   endtask

   task automatic t_bor;
      int n;
      int e;
      for (int s = 0; s < 8; s++) begin
         wr(32'h8, 32'(s));
         rd_chk(32'h8, 32'(s));
         @(posedge clk_i);
         brownout_i <= 1'b1;
         repeat (5) @(posedge clk_i);
         #1 check(system_reset_o, 1'b1);
         @(posedge clk_i);
         brownout_i <= 1'b0;
         repeat (6) @(posedge clk_i);
         brownout_i <= 1'b1;
         @(posedge clk_i);
         brownout_i <= 1'b0;
         wait_rel(n);
         e = BOR_T + MS_T * ((s == 0) ? 0 : (1 << s));
         check(32'(n >= e - 1 && n <= e + 3), 32'h1);
      end
      rd_chk(32'h0, 32'h3);
      wr(32'h0, 32'h80d3);
      rd_chk(32'h0, 32'h0);
   endtask

   task automatic t_soft;
      @(posedge clk_i);
      soft_reset_i <= 1'b1;
      @(posedge clk_i);
      soft_reset_i <= 1'b0;
      #1 check(system_reset_o, 1'b1);
      check(clock_reinit_o, 1'b0);
      @(posedge clk_i);
      #1 check(system_reset_o, 1'b0);
      rd_chk(32'h0, 32'h40);
      check(irq_o, 1'b0);
      wr(32'h4, 32'h40);
      repeat (2) @(posedge clk_i);
      #1 check(irq_o, 1'b1);
      wr(32'h0, 32'h40);
      repeat (2) @(posedge clk_i);
      #1 check(irq_o, 1'b0);
      rd_chk(32'h4, 32'h40);
   endtask

   task automatic t_ce;
      @(posedge clk_i);
      ce <= 1'b0;
      soft_reset_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1 check(system_reset_o, 1'b0);
      check(hreadyout, 1'b0);
      @(posedge clk_i);
      ce <= 1'b1;
      soft_reset_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1 check(system_reset_o, 1'b0);
      rd_chk(32'h0, 32'h0);
   endtask

   task automatic t_wdt;
      int n;
      @(posedge clk_i);
      wdt_expire_i <= 1'b1;
      #1 check(system_reset_o, 1'b1);
      @(posedge clk_i);
      wdt_expire_i <= 1'b0;
      #1 check(clock_reinit_o, 1'b0);
      wait_rel(n);
      check(32'(n), 32'h1);
      rd_chk(32'h0, 32'h10);
      wr(32'h0, 32'h10);
      @(posedge clk_i);
      cpu_sleep_i <= 1'b1;
      wdt_expire_i <= 1'b1;
      #1 check(system_reset_o, 1'b0);
      @(posedge clk_i);
      wdt_expire_i <= 1'b0;
      #1 check(wake_o, 1'b1);
      check(system_reset_o, 1'b0);
      @(posedge clk_i);
      cpu_sleep_i <= 1'b0;
      #1 check(wake_o, 1'b0);
      rd_chk(32'h0, 32'h0);
   endtask

   task automatic t_trap;
      logic [3:0] busy[4] = '{4'hf, 4'he, 4'hd, 4'hf};
      logic [3:0] fresh[4] = '{4'hd, 4'hd, 4'he, 4'hc};
      logic       hit[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         trap_busy_i <= '{valid: 1'b1, level: busy[i]};
         trap_new_i <= '{valid: 1'b1, level: fresh[i]};
         @(posedge clk_i);
         trap_busy_i <= '0;
         trap_new_i <= '0;
         #1 check(system_reset_o, hit[i]);
         rd_chk(32'h0, hit[i] ? 32'h8000 : 32'h0);
         wr(32'h0, 32'h8000);
      end
   endtask

   task automatic t_pin;
      int n;
      int hi;
      hi = 0;
      @(posedge clk_i);
      start <= 1'b1;
      len <= 8'd50;
      @(posedge clk_i);
      start <= 1'b0;
      repeat (60) begin
         @(posedge clk_i);
         #1 hi = hi | system_reset_o;
      end
      check(32'(hi), 32'h0);
      @(posedge clk_i);
      start <= 1'b1;
      len <= 8'd120;
      @(posedge clk_i);
      start <= 1'b0;
      repeat (110) @(posedge clk_i);
      #1 check(system_reset_o, 1'b1);
      wait_rel(n);
      check(32'(n < 30), 32'h1);
      rd_chk(32'h0, 32'h80);
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_por;
      t_bor;
      t_soft;
      t_ce;
      t_wdt;
      t_trap;
      t_pin;
      tally_and_finish;
   end
endmodule
